/* shared/pid_consts.svh */
// offsets, field positions, reset values and timing counts of the process controller
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define PID_OFS_CTRL      12'h000
`define PID_OFS_FIXED_SP  12'h004
`define PID_OFS_START_VAL 12'h008
`define PID_OFS_RAMP_UP   12'h00c
`define PID_OFS_RAMP_DOWN 12'h010
`define PID_OFS_KP        12'h014
`define PID_OFS_TI        12'h018
`define PID_OFS_TD        12'h01c
`define PID_OFS_UPPER     12'h020
`define PID_OFS_LOWER     12'h024
`define PID_OFS_OUTPUT    12'h028
`define PID_OFS_ACTUAL    12'h02c

// ************************************************
// control register field positions
// ************************************************
`define PID_BIT_ENABLE     0
`define PID_BIT_MAIN_SEL   1
`define PID_LSB_SP_SRC     4
`define PID_LSB_ACT_SRC    8
`define PID_BIT_FIXED_SEL  12
`define PID_BIT_SPEED_SRC  16

// ************************************************
// reset values (percent scale: 16'h4000 is 100 %)
// ************************************************
`define PID_RST_FIXED_SP   16'h0000
`define PID_RST_START_VAL  16'h0000
`define PID_RST_RAMP_MS    16'h03e8
`define PID_RST_KP         16'h0100
`define PID_RST_TI_MS      16'h7530
`define PID_RST_TD_MS      16'h0000
`define PID_RST_UPPER      16'h4000
`define PID_RST_LOWER      16'h0000
`define PID_FULL_SCALE     16'h4000

// ************************************************
// timing: control cycle length and clock period
// ************************************************
`define PID_CYCLE_NS       1000000
`define PID_CLK_NS         40
`define PID_CYCLE_CLKS     (`PID_CYCLE_NS / `PID_CLK_NS)

`endif

/* shared/pid_pkg.sv */
// types shared by the process controller
package pid_pkg;

  // software configuration carried as one word
  typedef struct packed {
    logic        speed_src;     // main_speed_setpoint_source
    logic        fixed_sel;     // fixed_setpoint_select
    logic [1:0]  act_src;       // actual_value_source
    logic [1:0]  sp_src;        // setpoint_source
    logic        main_sel;      // main_setpoint_select
    logic        enable;        // controller_enable
    logic [15:0] fixed_sp;      // fixed_setpoint_value
    logic [15:0] start_val;
    logic [15:0] ramp_up_ms;    // ramp_up_time
    logic [15:0] ramp_down_ms;  // ramp_down_time
    logic [15:0] kp;            // proportional_gain, 8.8
    logic [15:0] ti_ms;         // integral_time
    logic [15:0] td_ms;         // derivative_time
    logic [15:0] upper;         // upper_output_limit
    logic [15:0] lower;         // lower_output_limit
  } pid_cfg_t;

  // setpoint source codes
  typedef enum logic [1:0] {
    PID_SP_ZERO  = 2'h0,
    PID_SP_FIXED = 2'h1,
    PID_SP_IN_A  = 2'h2,
    PID_SP_IN_B  = 2'h3
  } pid_sp_src_t;

endpackage

/* verilog/pid_controller.sv */
// process pid controller with apb register access
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.svh"

// Behaviour
// - output is sum of P, I, D
// - runs only when enable set, resets zero
// - start value used while ramp below it, main_sel clear
// - setpoint ramp, separate up/down times, 1 s
// - derivative time defaults zero, no effect
// - proportional gain scales P, default one
// - integral time default thirty seconds
// - selectable setpoint source, fixed setpoint option
// - selectable actual value source, default zero
// - output routable to main speed setpoint
// - output clamped between limits, 100/0 %
module pid_controller
  import pid_pkg::*;
#(
  parameter int CYCLE_CLKS = `PID_CYCLE_CLKS
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [15:0] analog_a_i,
  input  wire logic [15:0] analog_b_i,
  input  wire logic [15:0] speed_setpoint_i,
  output logic      [15:0] controller_output_o,
  output logic      [15:0] main_speed_setpoint_o,
  output logic             control_tick_o
);

  // ************************************************
  // declarations
  // ************************************************
  pid_cfg_t                 cfg_ff;
  logic        [15:0]       a_meta_ff, a_ff, b_meta_ff, b_ff, spd_meta_ff, spd_ff;
  logic        [31:0]       cnt_ff;
  logic                     tick;
  logic signed [15:0]       ramp_ff, nxt_ramp;
  logic signed [15:0]       act_ff;
  logic signed [55:0]       integ_ff, nxt_integ;
  logic signed [55:0]       kpe_prev_ff, kpe;
  logic signed [15:0]       nxt_out;
  logic signed [15:0]       sp_src, act_src, sp_eff;
  logic                     acc, wr, rd, mapped;
  logic        [31:0]       rd_word;

  // sign extension to the working width
  function automatic logic signed [55:0] sx(input logic [15:0] v);
    sx = {{40{v[15]}}, v};
  endfunction

  // unsigned extension to the working width
  function automatic logic signed [55:0] ux(input logic [15:0] v);
    ux = {40'h00_0000_0000, v};
  endfunction

  // ************************************************
  // input synchronisers
  // ************************************************
  // two flops on every pin word before use
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      a_meta_ff   <= 16'h0000;
      a_ff        <= 16'h0000;
      b_meta_ff   <= 16'h0000;
      b_ff        <= 16'h0000;
      spd_meta_ff <= 16'h0000;
      spd_ff      <= 16'h0000;
    end else begin
      a_meta_ff   <= analog_a_i;
      a_ff        <= a_meta_ff;
      b_meta_ff   <= analog_b_i;
      b_ff        <= b_meta_ff;
      spd_meta_ff <= speed_setpoint_i;
      spd_ff      <= spd_meta_ff;
    end
  end

  // ************************************************
  // apb slave
  // ************************************************
  // access phase answered one cycle after it starts
  assign acc = psel_i & penable_i & ~pready_o;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;

  // read decode
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (paddr_i)
      `PID_OFS_CTRL: begin
        rd_word[`PID_BIT_ENABLE]                     = cfg_ff.enable;
        rd_word[`PID_BIT_MAIN_SEL]                   = cfg_ff.main_sel;
        rd_word[`PID_LSB_SP_SRC +: 2]                = cfg_ff.sp_src;
        rd_word[`PID_LSB_ACT_SRC +: 2]               = cfg_ff.act_src;
        rd_word[`PID_BIT_FIXED_SEL]                  = cfg_ff.fixed_sel;
        rd_word[`PID_BIT_SPEED_SRC]                  = cfg_ff.speed_src;
      end
      `PID_OFS_FIXED_SP:  rd_word[15:0] = cfg_ff.fixed_sp;
      `PID_OFS_START_VAL: rd_word[15:0] = cfg_ff.start_val;
      `PID_OFS_RAMP_UP:   rd_word[15:0] = cfg_ff.ramp_up_ms;
      `PID_OFS_RAMP_DOWN: rd_word[15:0] = cfg_ff.ramp_down_ms;
      `PID_OFS_KP:        rd_word[15:0] = cfg_ff.kp;
      `PID_OFS_TI:        rd_word[15:0] = cfg_ff.ti_ms;
      `PID_OFS_TD:        rd_word[15:0] = cfg_ff.td_ms;
      `PID_OFS_UPPER:     rd_word[15:0] = cfg_ff.upper;
      `PID_OFS_LOWER:     rd_word[15:0] = cfg_ff.lower;
      `PID_OFS_OUTPUT:    rd_word       = {ramp_ff, controller_output_o};
      `PID_OFS_ACTUAL:    rd_word[15:0] = act_ff;
      default:            mapped        = 1'b0;
    endcase
  end

  // answer flops
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= acc;
      pslverr_o <= acc & ~mapped;
      prdata_o  <= (rd & mapped) ? rd_word : 32'h0000_0000;
    end
  end

  // configuration registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_ff.speed_src    <= 1'b0;
      cfg_ff.fixed_sel    <= 1'b0;
      cfg_ff.act_src      <= 2'h0;
      cfg_ff.sp_src       <= 2'h0;
      cfg_ff.main_sel     <= 1'b0;
      cfg_ff.enable       <= 1'b0;
      cfg_ff.fixed_sp     <= `PID_RST_FIXED_SP;
      cfg_ff.start_val    <= `PID_RST_START_VAL;
      cfg_ff.ramp_up_ms   <= `PID_RST_RAMP_MS;
      cfg_ff.ramp_down_ms <= `PID_RST_RAMP_MS;
      cfg_ff.kp           <= `PID_RST_KP;
      cfg_ff.ti_ms        <= `PID_RST_TI_MS;
      cfg_ff.td_ms        <= `PID_RST_TD_MS;
      cfg_ff.upper        <= `PID_RST_UPPER;
      cfg_ff.lower        <= `PID_RST_LOWER;
    end else if (wr) begin
      unique case (paddr_i)
        `PID_OFS_CTRL: begin
          cfg_ff.enable    <= pwdata_i[`PID_BIT_ENABLE];
          cfg_ff.main_sel  <= pwdata_i[`PID_BIT_MAIN_SEL];
          cfg_ff.sp_src    <= pwdata_i[`PID_LSB_SP_SRC +: 2];
          cfg_ff.act_src   <= pwdata_i[`PID_LSB_ACT_SRC +: 2];
          cfg_ff.fixed_sel <= pwdata_i[`PID_BIT_FIXED_SEL];
          cfg_ff.speed_src <= pwdata_i[`PID_BIT_SPEED_SRC];
        end
        `PID_OFS_FIXED_SP:  cfg_ff.fixed_sp     <= pwdata_i[15:0];
        `PID_OFS_START_VAL: cfg_ff.start_val    <= pwdata_i[15:0];
        `PID_OFS_RAMP_UP:   cfg_ff.ramp_up_ms   <= pwdata_i[15:0];
        `PID_OFS_RAMP_DOWN: cfg_ff.ramp_down_ms <= pwdata_i[15:0];
        `PID_OFS_KP:        cfg_ff.kp           <= pwdata_i[15:0];
        `PID_OFS_TI:        cfg_ff.ti_ms        <= pwdata_i[15:0];
        `PID_OFS_TD:        cfg_ff.td_ms        <= pwdata_i[15:0];
        `PID_OFS_UPPER:     cfg_ff.upper        <= pwdata_i[15:0];
        `PID_OFS_LOWER:     cfg_ff.lower        <= pwdata_i[15:0];
        default: ;                                // read-only or unmapped
      endcase
    end
  end

  // ************************************************
  // control cycle timer
  // ************************************************
  // one tick per fixed control cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 32'h0000_0000;
    end else if (cnt_ff == 32'(CYCLE_CLKS - 1)) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end
  assign tick = (cnt_ff == 32'(CYCLE_CLKS - 1));

  // ************************************************
  // source selection
  // ************************************************
  // setpoint and actual value multiplexers
  always_comb begin
    unique case (pid_sp_src_t'(cfg_ff.sp_src))
      PID_SP_ZERO:  sp_src = 16'sh0000;
      PID_SP_FIXED: sp_src = cfg_ff.fixed_sel ? cfg_ff.fixed_sp : 16'sh0000;
      PID_SP_IN_A:  sp_src = a_ff;
      PID_SP_IN_B:  sp_src = b_ff;
    endcase
    unique case (cfg_ff.act_src)
      2'h1:    act_src = a_ff;
      2'h2:    act_src = b_ff;
      default: act_src = 16'sh0000;
    endcase
  end

  // ************************************************
  // ramp generator and start value
  // ************************************************
  // step per cycle: full scale over the ramp time in ms
  always_comb begin
    logic [31:0]       up_step, dn_step;
    logic signed [55:0] r;
    up_step = 32'h0000_0000;
    dn_step = 32'h0000_0000;
    r       = sx(ramp_ff);
    up_step = (cfg_ff.ramp_up_ms == 16'h0000) ? 32'h0001_0000
            : 32'h0000_0000 | (32'(`PID_FULL_SCALE) / 32'(cfg_ff.ramp_up_ms));
    dn_step = (cfg_ff.ramp_down_ms == 16'h0000) ? 32'h0001_0000
            : 32'h0000_0000 | (32'(`PID_FULL_SCALE) / 32'(cfg_ff.ramp_down_ms));
    if (up_step == 32'h0000_0000) up_step = 32'h0000_0001;
    if (dn_step == 32'h0000_0000) dn_step = 32'h0000_0001;
    if (sp_src > ramp_ff) begin
      r = r + 56'(up_step);
      if (r > sx(sp_src)) r = sx(sp_src);
    end else if (sp_src < ramp_ff) begin
      r = r - 56'(dn_step);
      if (r < sx(sp_src)) r = sx(sp_src);
    end
    nxt_ramp = r[15:0];
  end

  // with main_sel clear, start value stands in until the ramp has reached it
  assign sp_eff = (!cfg_ff.main_sel && (ramp_ff < $signed(cfg_ff.start_val)))
                ? $signed(cfg_ff.start_val) : ramp_ff;

  // ************************************************
  // pid arithmetic (values scaled by 256)
  // ************************************************
  always_comb begin
    logic signed [55:0] err, i_inc, d_term, sum, lo, hi, outw;
    err       = sx(sp_eff) - sx(act_src);
    kpe       = 56'(err * ux(cfg_ff.kp));
    i_inc     = (cfg_ff.ti_ms == 16'h0000) ? 56'sh0
              : kpe / ux(cfg_ff.ti_ms);
    d_term    = 56'((kpe - kpe_prev_ff) * ux(cfg_ff.td_ms));
    lo        = 56'(sx(cfg_ff.lower) <<< 8);
    hi        = 56'(sx(cfg_ff.upper) <<< 8);
    nxt_integ = integ_ff + i_inc;
    if (nxt_integ > hi) nxt_integ = hi;           // anti-windup
    if (nxt_integ < lo) nxt_integ = lo;
    sum  = kpe + nxt_integ + d_term;
    outw = sum >>> 8;
    if (outw > sx(cfg_ff.upper)) outw = sx(cfg_ff.upper);
    if (outw < sx(cfg_ff.lower)) outw = sx(cfg_ff.lower);
    nxt_out = outw[15:0];
  end

  // ************************************************
  // controller state
  // ************************************************
  // ramp, integral and output update once per cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_ff             <= 16'sh0000;
      act_ff              <= 16'sh0000;
      integ_ff            <= 56'sh0;
      kpe_prev_ff         <= 56'sh0;
      controller_output_o <= 16'h0000;
    end else if (tick) begin
      act_ff <= act_src;
      if (!cfg_ff.enable) begin
        ramp_ff             <= 16'sh0000;
        integ_ff            <= 56'sh0;
        kpe_prev_ff         <= 56'sh0;
        controller_output_o <= 16'h0000;
      end else begin
        ramp_ff             <= nxt_ramp;
        integ_ff            <= nxt_integ;
        kpe_prev_ff         <= kpe;
        controller_output_o <= nxt_out;
      end
    end
  end

  // speed setpoint routing and cycle strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_speed_setpoint_o <= 16'h0000;
      control_tick_o        <= 1'b0;
    end else begin
      main_speed_setpoint_o <= cfg_ff.speed_src ? controller_output_o : spd_ff;
      control_tick_o        <= tick;
    end
  end

endmodule
`default_nettype wire

/* bench/pid_process_model.sv */
// far-side model: process sensor, setpoint input and drive speed path
`timescale 1ns/10ps
`default_nettype none
module pid_process_model (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] setpoint_i,
  input  wire logic [15:0] actual_i,
  input  wire logic [15:0] speed_i,
  output logic      [15:0] analog_a_o,
  output logic      [15:0] analog_b_o,
  output logic      [15:0] speed_setpoint_o
);
  // sensor words settle one clock after the process value moves
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      analog_a_o       <= 16'h0000;
      analog_b_o       <= 16'h0000;
      speed_setpoint_o <= 16'h0000;
    end else begin
      analog_a_o       <= setpoint_i;
      analog_b_o       <= actual_i;
      speed_setpoint_o <= speed_i;
    end
  end
endmodule
`default_nettype wire

/* bench/pid_controller_props.sv */
// port checker for the process pid controller
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.svh"
module pid_controller_props
  import pid_pkg::*;
#(
  parameter int CYCLE_CLKS = `PID_CYCLE_CLKS
) (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [15:0] analog_a_i,
  input wire logic [15:0] analog_b_i,
  input wire logic [15:0] speed_setpoint_i,
  input wire logic [15:0] controller_output_o,
  input wire logic [15:0] main_speed_setpoint_o,
  input wire logic        control_tick_o
);
  logic        en_ff;
  logic        spd_ff;
  logic        seen_ff;
  logic [31:0] cnt_ff;
  wire         ctrl_wr = psel_i & penable_i & ~pready_o & pwrite_i & (paddr_i == `PID_OFS_CTRL);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // ************************************************
  // shadow of enable and routing bits
  // ************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff  <= 1'b0;
      spd_ff <= 1'b0;
    end else if (ctrl_wr) begin
      en_ff  <= pwdata_i[`PID_BIT_ENABLE];
      spd_ff <= pwdata_i[`PID_BIT_SPEED_SRC];
    end
  end
  // clocks since the last control tick
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= 32'h0;
      seen_ff <= 1'b0;
    end else begin
      cnt_ff  <= control_tick_o ? 32'h0 : cnt_ff + 32'h1;
      seen_ff <= seen_ff | control_tick_o;
    end
  end
  a_ready_one_late: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  a_ready_one_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0)
    else $error("read data outside answer");
  a_tick_one_pulse: assert property (control_tick_o |=> !control_tick_o [*8])
    else $error("tick not a single pulse");
  a_tick_period: assert property (control_tick_o && seen_ff |-> cnt_ff == CYCLE_CLKS - 1)
    else $error("control cycle length wrong");
  // output and tick strobe launch from the same edge
  a_out_at_tick: assert property ($changed(controller_output_o) |-> control_tick_o)
    else $error("output moved off the tick");
  // enable as seen at the update edge
  a_off_out_zero: assert property (control_tick_o && !$past(en_ff)
    |-> controller_output_o == 16'h0)
    else $error("output nonzero while disabled");
  // routed setpoint trails the output by one clock
  a_speed_route: assert property (control_tick_o && spd_ff && $past(spd_ff)
    |-> main_speed_setpoint_o == $past(controller_output_o))
    else $error("speed setpoint not routed");
endmodule
bind pid_controller pid_controller_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (
  .clock_i               (clock_i),
  .rst_n_i               (rst_n_i),
  .psel_i                (psel_i),
  .penable_i             (penable_i),
  .pwrite_i              (pwrite_i),
  .paddr_i               (paddr_i),
  .pwdata_i              (pwdata_i),
  .prdata_o              (prdata_o),
  .pready_o              (pready_o),
  .pslverr_o             (pslverr_o),
  .analog_a_i            (analog_a_i),
  .analog_b_i            (analog_b_i),
  .speed_setpoint_i      (speed_setpoint_i),
  .controller_output_o   (controller_output_o),
  .main_speed_setpoint_o (main_speed_setpoint_o),
  .control_tick_o        (control_tick_o)
);
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the process pid controller
`timescale 1ns/10ps
`default_nettype none
`include "pid_consts.svh"
module tb;
  localparam int CYC = 20;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] a_val = 16'h3000;
  logic [15:0] b_val = 16'h0000;
  logic [15:0] s_val = 16'h0000;
  logic [15:0] ana_a, ana_b, spd_in, out, main_sp;
  logic        tick;
  logic [32:0] rd_q[$];
  logic [32:0] out_q[$];
  logic [15:0] rst_v [10] = '{16'h0, 16'h0, 16'h0, 16'h3e8, 16'h3e8,
                              16'h100, 16'h7530, 16'h0, 16'h4000, 16'h0};
  int          num_errors = 0;
  int          cmp_count = 0;
  int          seed = 68;
  logic        ms;
  logic        tick_d = 1'b0;
  always #20 clock_i = ~clock_i;
  pid_process_model u_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .setpoint_i(a_val),
    .actual_i(b_val), .speed_i(s_val), .analog_a_o(ana_a), .analog_b_o(ana_b),
    .speed_setpoint_o(spd_in));
  pid_controller #(.CYCLE_CLKS(CYC)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .analog_a_i(ana_a), .analog_b_i(ana_b), .speed_setpoint_i(spd_in),
    .controller_output_o(out), .main_speed_setpoint_o(main_sp), .control_tick_o(tick));
  // ************************************************
  // shared tasks
  // ************************************************
  task automatic final_report();
    if (rd_q.size() > 0 || out_q.size() > 0) num_errors++;  // notes never compared
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int n;
    n = 0;
    if (!wr) rd_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
    @(posedge clock_i);
  endtask
  // wait for n control ticks
  task automatic wait_ticks(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clock_i);
        k++;
      end while (tick !== 1'b1 && k < 4 * CYC);
      if (k >= 4 * CYC) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  // note expected {speed setpoint, output} at the n-th tick from now
  task automatic expect_out(input int n, input logic [31:0] v);
    wait_ticks(n - 1);
    @(posedge clock_i);
    out_q.push_back({1'b0, v});
    wait_ticks(1);
    @(posedge clock_i);
  endtask
  // ************************************************
  // result watchers
  // ************************************************
  always @(negedge clock_i) begin
    if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0)
      chk({pslverr, prdata}, rd_q.pop_front());
    // routed setpoint settles one clock after the tick strobe
    if (tick_d && out_q.size() > 0)
      chk({1'b0, main_sp, out}, out_q.pop_front());
    tick_d = (tick === 1'b1);
  end
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    b_val <= 16'($random(seed)) & 16'h07ff;
    s_val <= 16'($random(seed));
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    // reset values, unmapped place, random readback
    for (int i = 0; i < 10; i++) apb(1'b0, 12'(i * 4), 32'h0, {17'h0, rst_v[i]});
    apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
    apb(1'b1, `PID_OFS_FIXED_SP, {16'h0, s_val}, 33'h0);
    apb(1'b0, `PID_OFS_FIXED_SP, 32'h0, {17'h0, s_val});
    // four-cycle ramp up, jump down, no integral, start value above ramp
    apb(1'b1, `PID_OFS_RAMP_UP, 32'h4, 33'h0);
    apb(1'b1, `PID_OFS_RAMP_DOWN, 32'h0, 33'h0);
    apb(1'b1, `PID_OFS_TI, 32'h0, 33'h0);
    apb(1'b1, `PID_OFS_START_VAL, 32'h2800, 33'h0);
    for (int m = 0; m < 2; m++) begin
      ms = m[0];
      apb(1'b1, `PID_OFS_CTRL, 32'h0, 33'h0);
      expect_out(2, {s_val, 16'h0});
      apb(1'b1, `PID_OFS_CTRL, 32'h221 | {15'h0, ms, 14'h0, ms, 1'b0}, 33'h0);
      if (ms) expect_out(2, {16'h1000 - b_val, 16'h1000 - b_val});
      else expect_out(2, {s_val, 16'h2800 - b_val});
      if (ms) expect_out(3, {16'h3000 - b_val, 16'h3000 - b_val});
      else expect_out(3, {s_val, 16'h3000 - b_val});
    end
    apb(1'b1, `PID_OFS_UPPER, 32'h1000, 33'h0);
    expect_out(2, {16'h1000, 16'h1000});
    b_val <= 16'h3800;
    expect_out(2, {16'h0, 16'h0});
    // status words: ramp at setpoint, output clamped, sampled actual value
    apb(1'b0, `PID_OFS_OUTPUT, 32'h0, {1'b0, 16'h3000, 16'h0000});
    apb(1'b0, `PID_OFS_ACTUAL, 32'h0, {17'h0, 16'h3800});
    final_report();
  end
endmodule
`default_nettype wire
